// File: verilog/codec_ctrl_defines.svh
`ifndef CODEC_CTRL_DEFINES_SVH
`define CODEC_CTRL_DEFINES_SVH

// ****************************************
// Register indices and byte addresses
// ****************************************
`define CODEC_CFG_IDX       8'h00
`define DAC_VOLUME_IDX      8'h02
`define DAC_MISC_IDX        8'h04
`define DAC_POWER_IDX       8'h05
`define CODEC_STATUS_IDX    8'h06
`define REG_ADDR(idx)       ((idx) * 4)

// ****************************************
// Field positions
// ****************************************
`define CFG_MCLK_HI         7
`define CFG_MCLK_LO         6
`define CFG_RATE_HI         5
`define CFG_RATE_LO         2
`define CFG_FMT_HI          1
`define CFG_FMT_LO          0
`define VOL_L_MUTE          15
`define VOL_L_HI            14
`define VOL_L_LO            8
`define VOL_R_MUTE          7
`define VOL_R_HI            6
`define VOL_R_LO            0
`define MISC_SLOW_STEP      1
`define MISC_STEP_DONE      0
`define PWR_DEEMPH          0
`define PWR_EFFECTS         1
`define PWR_DAC_ON          2

// ****************************************
// Reset values
// ****************************************
`define CODEC_CFG_RST       8'h00
`define DAC_VOLUME_RST      16'h8080

// ****************************************
// Codes
// ****************************************
`define MCLK_512FS          2'h2
`define RATE_11K025         4'h1
`define RATE_22K05          4'h4
`define RATE_44K1           4'h7
`define RATE_48K            4'h8
`define FMT_16BIT           2'h0
`define VOL_MUTE_CODE       8'h80

// ****************************************
// Timing
// ****************************************
`define PCLK_MHZ            200
`define SOFT_STEP_FAST_US   20
`define SOFT_STEP_SLOW_US   40
`define SOFT_STEP_FAST_CYC  (`SOFT_STEP_FAST_US * `PCLK_MHZ)
`define SOFT_STEP_SLOW_CYC  (`SOFT_STEP_SLOW_US * `PCLK_MHZ)

`endif

// File: verilog/codec_ctrl_pkg.sv
package codec_ctrl_pkg;

    typedef enum logic [2:0] {
        SEQ_OFF,
        SEQ_RUN,
        SEQ_FX_DOWN,
        SEQ_PWR_DOWN
    } seq_e;

    typedef struct packed {
        logic       pll_power_down;
        logic       direct_mclk;
        logic       family_48k;
        logic [9:0] oversample_ratio;
    } clk_cfg_s;

    typedef struct packed {
        logic       dac_power_on;
        logic       deemph_on;
        logic       effects_on;
        logic [7:0] left_actual;
        logic [7:0] right_actual;
    } dac_ctl_s;

endpackage : codec_ctrl_pkg

// File: verilog/vol_soft_step.sv
`timescale 1ns/1ps
`default_nettype none
`include "codec_ctrl_defines.svh"

module vol_soft_step (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       tick,
    input  wire logic [7:0] target,
    output logic      [7:0] actual,
    output logic            done
);
    typedef struct packed {
        logic [7:0] actual;
    } step_state_s;

    step_state_s st_reg;
    step_state_s st_next;

    always_comb begin
        st_next = st_reg;
        if (tick && st_reg.actual < target) begin
            st_next.actual = st_reg.actual + 8'h01;
        end else if (tick && st_reg.actual > target) begin
            st_next.actual = st_reg.actual - 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg.actual <= `VOL_MUTE_CODE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign actual = st_reg.actual;
    assign done   = (st_reg.actual == target);

    // ****************************************
    // Checks
    // ****************************************
    a_step_on_tick: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(actual) |-> $past(tick)) else $error("volume moved without a tick");
    a_step_by_one: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(actual) |-> (actual == $past(actual) + 8'h01) || (actual + 8'h01 == $past(actual)))
        else $error("volume step larger than one code");
    a_step_redirect: assert property (@(posedge pclk) disable iff (!presetn)
        tick && !done |=> $changed(actual)) else $error("ramp did not follow target");

endmodule : vol_soft_step
`default_nettype wire

// File: verilog/codec_rate_vol_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "codec_ctrl_defines.svh"

module codec_rate_vol_ctrl
    import codec_ctrl_pkg::*;
#(
    parameter int STEP_SLOW_CYC = `SOFT_STEP_SLOW_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        bclk,
    input  wire logic        lrclk,
    output clk_cfg_s         clk_cfg,
    output dac_ctl_s         dac_ctl,
    output logic      [1:0]  serial_format_select,
    output logic      [3:0]  sample_rate_select
);
    localparam logic [13:0] FAST_CYC = 14'(`SOFT_STEP_FAST_CYC);
    localparam logic [13:0] SLOW_CYC = 14'(STEP_SLOW_CYC);

    typedef struct packed {
        logic [7:0]  cfg;
        logic [15:0] vol;
        logic        slow_soft_step;
        logic [2:0]  pwr;
        logic        deemph_applied;
        logic        effects_applied;
        logic        dac_on;
        seq_e        seq;
        logic [13:0] tick_cnt;
        logic [1:0]  bclk_s;
        logic [1:0]  lr_s;
        logic        bclk_d;
        logic        lr_d;
        logic [6:0]  bclk_cnt;
        logic [6:0]  bclk_per_frame;
        logic [31:0] rdata;
    } ctrl_state_s;

    ctrl_state_s st_reg;
    ctrl_state_s st_next;

    logic        tick;
    logic [7:0]  tgt_l;
    logic [7:0]  tgt_r;
    logic [7:0]  act_l;
    logic [7:0]  act_r;
    logic        done_l;
    logic        done_r;
    logic        ramp_to_mute;
    logic        step_done;
    logic        rate_err;
    logic        link_err;
    logic [3:0]  rate;
    logic [9:0]  osr;
    logic        fam48;
    logic        direct;
    logic        wr_en;
    logic        rd_setup;
    logic        mapped;
    logic [31:0] rd_mux;

    // ****************************************
    // Rate and clock decode
    // ****************************************
    assign rate = st_reg.cfg[`CFG_RATE_HI:`CFG_RATE_LO];

    always_comb begin
        rate_err = 1'b0;
        unique case (rate)
            4'h0: osr = 10'd768;
            4'h1: osr = 10'd512;
            4'h2: osr = 10'd512;
            4'h3: osr = 10'd384;
            4'h4: osr = 10'd256;
            4'h5: osr = 10'd256;
            4'h6: osr = 10'd192;
            4'h7: osr = 10'd128;
            4'h8: osr = 10'd128;
            default: begin
                osr      = 10'd128;
                rate_err = 1'b1;
            end
        endcase
    end

    assign fam48  = !(rate == `RATE_11K025 || rate == `RATE_22K05 || rate == `RATE_44K1);
    assign direct = (rate == `RATE_44K1 || rate == `RATE_48K)
                    && st_reg.cfg[`CFG_MCLK_HI:`CFG_MCLK_LO] == `MCLK_512FS;

    // Master clock ratio and a 44.1/48 kHz rate decide; bit clock phase is never compared
    assign clk_cfg.pll_power_down   = direct;
    assign clk_cfg.direct_mclk      = direct;
    assign clk_cfg.family_48k       = fam48;
    // Ratio steers the downstream interpolator and its image filter
    assign clk_cfg.oversample_ratio = osr;
    assign sample_rate_select       = rate;

    // Only 16-bit format allowed with 32 bit clocks per frame
    assign serial_format_select = (st_reg.bclk_per_frame == 7'd32) ? `FMT_16BIT
                                  : st_reg.cfg[`CFG_FMT_HI:`CFG_FMT_LO];
    assign link_err = !(st_reg.bclk_per_frame == 7'd32 || st_reg.bclk_per_frame == 7'd48
                        || st_reg.bclk_per_frame == 7'd64);

    // ****************************************
    // Soft-step engines
    // ****************************************
    assign ramp_to_mute = (st_reg.seq != SEQ_RUN);
    assign tgt_l = (ramp_to_mute || st_reg.vol[`VOL_L_MUTE]) ? `VOL_MUTE_CODE
                   : {1'b0, st_reg.vol[`VOL_L_HI:`VOL_L_LO]};
    assign tgt_r = (ramp_to_mute || st_reg.vol[`VOL_R_MUTE]) ? `VOL_MUTE_CODE
                   : {1'b0, st_reg.vol[`VOL_R_HI:`VOL_R_LO]};

    assign tick = (st_reg.tick_cnt == 14'h0000);

    vol_soft_step u_step_l (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick),
        .target  (tgt_l),
        .actual  (act_l),
        .done    (done_l)
    );

    vol_soft_step u_step_r (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick),
        .target  (tgt_r),
        .actual  (act_r),
        .done    (done_r)
    );

    assign step_done = done_l && done_r && (st_reg.seq == SEQ_RUN || st_reg.seq == SEQ_OFF);

    // ****************************************
    // Register port
    // ****************************************
    // Registers live only behind this port
    assign mapped = paddr == 8'(`REG_ADDR(`CODEC_CFG_IDX)) || paddr == 8'(`REG_ADDR(`DAC_VOLUME_IDX))
                 || paddr == 8'(`REG_ADDR(`DAC_MISC_IDX)) || paddr == 8'(`REG_ADDR(`DAC_POWER_IDX))
                 || paddr == 8'(`REG_ADDR(`CODEC_STATUS_IDX));
    assign wr_en    = psel && penable && pwrite && mapped;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;
    assign prdata   = st_reg.rdata;

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            8'(`REG_ADDR(`CODEC_CFG_IDX)):  rd_mux = {24'h00_0000, st_reg.cfg};
            8'(`REG_ADDR(`DAC_VOLUME_IDX)): rd_mux = {16'h0000, st_reg.vol};
            8'(`REG_ADDR(`DAC_MISC_IDX)):   rd_mux = {30'h0000_0000, st_reg.slow_soft_step, step_done};
            8'(`REG_ADDR(`DAC_POWER_IDX)):  rd_mux = {29'h0000_0000, st_reg.pwr};
            8'(`REG_ADDR(`CODEC_STATUS_IDX)): rd_mux = {act_r, act_l, 5'h00, st_reg.dac_on, direct,
                                                         rate_err, link_err, st_reg.bclk_per_frame};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_next = st_reg;
        if (rd_setup) begin
            st_next.rdata = rd_mux;
        end
        if (wr_en) begin
            unique case (paddr)
                8'(`REG_ADDR(`CODEC_CFG_IDX)):  st_next.cfg = pwdata[7:0];
                8'(`REG_ADDR(`DAC_VOLUME_IDX)): st_next.vol = pwdata[15:0];
                8'(`REG_ADDR(`DAC_MISC_IDX)):   st_next.slow_soft_step = pwdata[`MISC_SLOW_STEP];
                8'(`REG_ADDR(`DAC_POWER_IDX)):  st_next.pwr = pwdata[2:0];
                default: ;
            endcase
        end

        // Step interval timer
        if (tick) begin
            st_next.tick_cnt = (st_reg.slow_soft_step ? SLOW_CYC : FAST_CYC) - 14'h0001;
        end else begin
            st_next.tick_cnt = st_reg.tick_cnt - 14'h0001;
        end

        // Power and effects sequencing
        unique case (st_reg.seq)
            SEQ_OFF: begin
                if (st_reg.pwr[`PWR_DAC_ON] && done_l && done_r) begin
                    st_next.dac_on          = 1'b1;
                    st_next.deemph_applied  = st_reg.pwr[`PWR_DEEMPH];
                    st_next.effects_applied = st_reg.pwr[`PWR_EFFECTS];
                    st_next.seq             = SEQ_RUN;
                end
            end
            SEQ_RUN: begin
                if (!st_reg.pwr[`PWR_DAC_ON]) begin
                    st_next.seq = SEQ_PWR_DOWN;
                end else if (st_reg.pwr[`PWR_DEEMPH] != st_reg.deemph_applied
                          || st_reg.pwr[`PWR_EFFECTS] != st_reg.effects_applied) begin
                    st_next.seq = SEQ_FX_DOWN;
                end
            end
            SEQ_FX_DOWN: begin
                if (done_l && done_r) begin
                    st_next.deemph_applied  = st_reg.pwr[`PWR_DEEMPH];
                    st_next.effects_applied = st_reg.pwr[`PWR_EFFECTS];
                    st_next.seq             = SEQ_RUN;
                end
            end
            SEQ_PWR_DOWN: begin
                if (done_l && done_r) begin
                    st_next.dac_on = 1'b0;
                    st_next.seq    = SEQ_OFF;
                end
            end
        endcase

        // Audio clock pins: two-stage synchronisers, then edge detect
        st_next.bclk_s = {st_reg.bclk_s[0], bclk};
        st_next.lr_s   = {st_reg.lr_s[0], lrclk};
        st_next.bclk_d = st_reg.bclk_s[1];
        st_next.lr_d   = st_reg.lr_s[1];
        if (st_reg.lr_s[1] && !st_reg.lr_d) begin
            st_next.bclk_per_frame = st_reg.bclk_cnt;
            st_next.bclk_cnt       = 7'h00;
        end
        if (st_reg.bclk_s[1] && !st_reg.bclk_d && st_next.bclk_cnt != 7'h7f) begin
            st_next.bclk_cnt = st_next.bclk_cnt + 7'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg.cfg             <= `CODEC_CFG_RST;
            st_reg.vol             <= `DAC_VOLUME_RST;
            st_reg.slow_soft_step  <= 1'b0;
            st_reg.pwr             <= 3'h0;
            st_reg.deemph_applied  <= 1'b0;
            st_reg.effects_applied <= 1'b0;
            st_reg.dac_on          <= 1'b0;
            st_reg.seq             <= SEQ_OFF;
            st_reg.tick_cnt        <= 14'h0000;
            st_reg.bclk_s          <= 2'h0;
            st_reg.lr_s            <= 2'h0;
            st_reg.bclk_d          <= 1'b0;
            st_reg.lr_d            <= 1'b0;
            st_reg.bclk_cnt        <= 7'h00;
            st_reg.bclk_per_frame  <= 7'h00;
            st_reg.rdata           <= 32'h0000_0000;
        end else begin
            st_reg <= st_next;
        end
    end

    assign dac_ctl.dac_power_on = st_reg.dac_on;
    assign dac_ctl.deemph_on    = st_reg.deemph_applied;
    assign dac_ctl.effects_on   = st_reg.effects_applied;
    assign dac_ctl.left_actual  = act_l;
    assign dac_ctl.right_actual = act_r;

    // ****************************************
    // Checks
    // ****************************************
    a_tick_fast: assert property (@(posedge pclk) disable iff (!presetn)
        tick && !st_reg.slow_soft_step |=> st_reg.tick_cnt == FAST_CYC - 14'h0001)
        else $error("fast step interval wrong");
    a_tick_slow: assert property (@(posedge pclk) disable iff (!presetn)
        tick && st_reg.slow_soft_step |=> st_reg.tick_cnt == SLOW_CYC - 14'h0001)
        else $error("slow step interval wrong");
    a_pll_direct: assert property (@(posedge pclk) disable iff (!presetn)
        clk_cfg.pll_power_down |-> clk_cfg.oversample_ratio == 10'd128 && !rate_err)
        else $error("PLL off outside 44.1/48 kHz");
    a_osr_family: assert property (@(posedge pclk) disable iff (!presetn)
        !clk_cfg.family_48k |-> clk_cfg.oversample_ratio inside {10'd512, 10'd256, 10'd128})
        else $error("44.1 kHz family ratio wrong");
    a_fx_at_mute: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(dac_ctl.effects_on) || $changed(dac_ctl.deemph_on)
        |-> $past(act_l) == `VOL_MUTE_CODE && $past(act_r) == `VOL_MUTE_CODE)
        else $error("effects changed while audible");
    a_off_at_mute: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(dac_ctl.dac_power_on) |-> act_l == `VOL_MUTE_CODE && act_r == `VOL_MUTE_CODE)
        else $error("DAC powered off while audible");
    a_on_from_mute: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(dac_ctl.dac_power_on) |-> act_l == `VOL_MUTE_CODE && act_r == `VOL_MUTE_CODE)
        else $error("DAC powered on above mute");
    a_done_flag: assert property (@(posedge pclk) disable iff (!presetn)
        step_done && st_reg.seq == SEQ_RUN |-> act_l == tgt_l && act_r == tgt_r)
        else $error("done flag with volume still moving");
    a_fmt_16bit: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.bclk_per_frame == 7'd32 |-> serial_format_select == `FMT_16BIT)
        else $error("wide format with 32 bit clocks");
    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !mapped |-> pslverr ##1 $stable(st_reg.cfg))
        else $error("unmapped access not refused");

    c_power_up: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(dac_ctl.dac_power_on));
    c_fx_change: cover property (@(posedge pclk) disable iff (!presetn)
        st_reg.seq == SEQ_FX_DOWN ##1 st_reg.seq == SEQ_RUN);
    c_power_down: cover property (@(posedge pclk) disable iff (!presetn)
        $fell(dac_ctl.dac_power_on));
    c_direct_mclk: cover property (@(posedge pclk) disable iff (!presetn)
        clk_cfg.direct_mclk && dac_ctl.dac_power_on);

endmodule : codec_rate_vol_ctrl
`default_nettype wire

// File: test/i2s_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host side audio clock source
// ****************************************
module i2s_host_model (
    input  wire logic       run,
    input  wire logic [6:0] bpf,
    output logic            bclk,
    output logic            lrclk
);
    int nb;
    initial begin
        bclk  = 1'b0;
        lrclk = 1'b0;
        #3.3;
        forever begin
            nb = int'(bpf);
            if (run) begin
                for (int i = 0; i < nb; i++) begin
                    #40 bclk = 1'b1;
                    #40 bclk = 1'b0;
                    lrclk = (i >= nb / 2 - 1) && (i != nb - 1);
                end
            end else begin
                #80;
            end
        end
    end
endmodule : i2s_host_model
`default_nettype wire

// File: test/tb_audio_codec_rate_and_volume_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "codec_ctrl_defines.svh"
// ****************************************
// Rate, link and soft-step checks
// ****************************************
module tb_audio_codec_rate_and_volume_control;
    import codec_ctrl_pkg::*;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} note_s;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, bclk, lrclk, run, seen;
    logic [7:0]  paddr, prev_l;
    logic [31:0] pwdata, prdata;
    logic [6:0]  bpf;
    logic [1:0]  fmt;
    logic [3:0]  rate;
    clk_cfg_s    clk_cfg;
    dac_ctl_s    dac_ctl;
    note_s       q[$];
    note_s       n;
    int          bad_count, cmp_count, gap, step_cyc;
    int          osr[9] = '{768, 512, 512, 384, 256, 256, 192, 128, 128};
    int          bl[4] = '{48, 40, 32, 64};

    codec_rate_vol_ctrl #(.STEP_SLOW_CYC(40)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bclk(bclk), .lrclk(lrclk), .clk_cfg(clk_cfg), .dac_ctl(dac_ctl),
        .serial_format_select(fmt), .sample_rate_select(rate));
    i2s_host_model host (.run(run), .bpf(bpf), .bclk(bclk), .lrclk(lrclk));

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] s, input logic [31:0] x);
        cmp_count++;
        if (s !== x) begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, s, x);
        end
    endtask : check

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                       input logic e);
        q.push_back('{d, m, e});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wait_l(input logic [7:0] t);
        for (int i = 0; i < 12000 && dac_ctl.left_actual !== t; i++) @(posedge pclk);
        check(32'(dac_ctl.left_actual), 32'(t));
    endtask : wait_l

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && q.size() > 0) begin
            n = q.pop_front();
            check(prdata & n.m, n.d & n.m);
            check({31'h0, pslverr}, {31'h0, n.e});
        end
        gap++;
        if (presetn && dac_ctl.left_actual !== prev_l) begin
            check({31'h0, dac_ctl.left_actual == prev_l + 8'h1 || dac_ctl.left_actual == prev_l - 8'h1}, 32'h1);
            if (seen) check({31'h0, gap >= step_cyc}, 32'h1);
            seen = 1'b1;
            gap = 0;
            prev_l = dac_ctl.left_actual;
        end
    end

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    initial begin
        repeat (90000) @(posedge pclk);
        bad_count++;
        final_report();
    end

    initial begin
        logic [1:0] m, f;
        {presetn, psel, penable, pwrite, run, seen, paddr, pwdata} = '0;
        {bpf, prev_l, step_cyc, gap, bad_count, cmp_count} = {7'd64, 8'h80, 32'd40, 96'd0};
        void'($urandom(14));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        run <= 1'b1;
        apb(1'b0, 8'h00, 32'h0, 32'hff, 1'b0);
        apb(1'b0, 8'h08, 32'h8080, 32'hffff, 1'b0);
        apb(1'b0, 8'h10, 32'h1, 32'h3, 1'b0);
        apb(1'b0, 8'h04, 32'h0, 32'hffffffff, 1'b1);
        apb(1'b1, 8'h0c, 32'h5, 32'h0, 1'b1);
        for (int i = 0; i < 9; i++) begin
            m = 2'($urandom % 3);
            f = 2'($urandom % 4);
            apb(1'b1, 8'h00, {24'h0, m, 4'(i), f}, 32'h0, 1'b0);
            check(32'(clk_cfg.oversample_ratio), 32'(osr[i]));
            check({31'h0, clk_cfg.family_48k}, {31'h0, !(i == 1 || i == 4 || i == 7)});
            check({30'h0, clk_cfg.pll_power_down, clk_cfg.direct_mclk}, {30'h0, {2{i >= 7 && m == 2'h2}}});
            check({26'h0, rate, fmt}, {26'h0, 4'(i), f});
        end
        apb(1'b1, 8'h00, {24'h0, 2'h2, 4'(9 + $urandom % 7), 2'h0}, 32'h0, 1'b0);
        apb(1'b0, 8'h18, 32'h100, 32'h700, 1'b0);
        check({22'h0, clk_cfg.oversample_ratio}, {22'h0, 10'd128});
        apb(1'b1, 8'h00, 32'ha3, 32'h0, 1'b0);
        for (int k = 0; k < 4; k++) begin
            bpf <= 7'(bl[k]);
            repeat (4000) @(posedge pclk);
            apb(1'b0, 8'h18, 32'(bl[k]) | (bl[k] % 16 == 0 ? 32'h200 : 32'h280), 32'h7ff, 1'b0);
            check(32'(fmt), bl[k] == 32 ? 32'h0 : 32'h3);
        end
        apb(1'b1, 8'h10, 32'h2, 32'h0, 1'b0);
        seen = 1'b0;
        apb(1'b0, 8'h10, 32'h3, 32'h3, 1'b0);
        apb(1'b1, 8'h14, 32'h4, 32'h0, 1'b0);
        for (int i = 0; i < 1000 && dac_ctl.dac_power_on !== 1'b1; i++) @(posedge pclk);
        check({31'h0, dac_ctl.dac_power_on}, 32'h1);
        apb(1'b1, 8'h08, 32'h0080, 32'h0, 1'b0);
        repeat (100) @(posedge pclk);
        apb(1'b0, 8'h10, 32'h2, 32'h3, 1'b0);
        apb(1'b1, 8'h08, 32'h7f80, 32'h0, 1'b0);
        wait_l(8'h7f);
        apb(1'b1, 8'h08, 32'h0080, 32'h0, 1'b0);
        wait_l(8'h00);
        check(32'(dac_ctl.right_actual), 32'h80);
        apb(1'b0, 8'h18, 32'h8000_0600, 32'hffff_0700, 1'b0);
        apb(1'b0, 8'h10, 32'h3, 32'h3, 1'b0);
        apb(1'b1, 8'h14, 32'h6, 32'h0, 1'b0);
        for (int i = 0; i < 12000 && dac_ctl.effects_on !== 1'b1; i++) @(posedge pclk);
        check(32'(dac_ctl.left_actual), 32'h80);
        wait_l(8'h00);
        apb(1'b1, 8'h14, 32'h2, 32'h0, 1'b0);
        for (int i = 0; i < 12000 && dac_ctl.dac_power_on !== 1'b0; i++) @(posedge pclk);
        check(32'(dac_ctl.left_actual), 32'h80);
        apb(1'b1, 8'h10, 32'h0, 32'h0, 1'b0);
        step_cyc = `SOFT_STEP_FAST_CYC;
        seen = 1'b0;
        apb(1'b1, 8'h08, 32'h7e80, 32'h0, 1'b0);
        apb(1'b1, 8'h14, 32'h6, 32'h0, 1'b0);
        wait_l(8'h7e);
        apb(1'b1, 8'h14, 32'h7, 32'h0, 1'b0);
        for (int i = 0; i < 12000 && dac_ctl.deemph_on !== 1'b1; i++) @(posedge pclk);
        check({30'h0, dac_ctl.deemph_on, dac_ctl.effects_on}, 32'h3);
        check(32'(dac_ctl.left_actual), 32'h80);
        final_report();
    end
endmodule : tb_audio_codec_rate_and_volume_control
`default_nettype wire
